// *** sim/sdsc_host_model.sv ***
`timescale 1ns/1ns
module sdsc_host_model (
  input  wire logic i_clock,
  output logic o_serial_clock,
  output logic o_serial_data,
  output logic o_load_strobe
);
  // link rests with its clock and strobe low between frames
  initial begin
    o_serial_clock = 1'b0;
    o_serial_data  = 1'b0;
    o_load_strobe  = 1'b0;
  end

  // shifts the low n bits of w, top bit first, then pulses the strobe;
  // every level is held four system clocks, a 160 ns link period
  task automatic send(input logic [31:0] w, input int n);
    @(posedge i_clock);
    for (int i = n - 1; i >= 0; i--) begin
      o_serial_data <= w[i];
      repeat (4) @(posedge i_clock);
      o_serial_clock <= 1'b1;
      repeat (4) @(posedge i_clock);
      o_serial_clock <= 1'b0;
    end
    repeat (4) @(posedge i_clock);
    o_load_strobe <= 1'b1;
    o_serial_data <= ~o_serial_data; // released line shows no stale bit
    repeat (4) @(posedge i_clock);
    o_load_strobe <= 1'b0;
  endtask
endmodule

// *** sim/sdsc_top_asserts.sv ***
`timescale 1ns/1ns
module sdsc_checker (
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic        i_chip_enable,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        o_charge_pump_up,
  input wire logic        o_charge_pump_down,
  input wire logic        o_charge_pump_oe_n,
  input wire logic [1:0]  o_ref_series_closed,
  input wire logic        o_ref_shunt_switch,
  input wire logic        o_power_down
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // bus handshake: one wait cycle, none while idle
  wait_first_a: assert property ($rose(i_avs_read || i_avs_write)
    |-> o_avs_waitrequest) else $error("new request not held off");
  wait_one_a: assert property ((i_avs_read || i_avs_write)
    && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus answer later than one cycle");
  wait_idle_a: assert property (!i_avs_read && !i_avs_write
    |-> !o_avs_waitrequest) else $error("wait raised while idle");
  rdata_hold_a: assert property (!i_avs_read
    |=> $stable(o_avs_readdata)) else $error("read data moved");

  // power-down outputs
  pd_pump_a: assert property (
    o_power_down |-> o_charge_pump_oe_n && !o_charge_pump_up
    && !o_charge_pump_down) else $error("pump active in power-down");
  pd_switch_a: assert property (
    o_power_down |-> o_ref_series_closed == 2'b00 && o_ref_shunt_switch)
    else $error("reference switches wrong in power-down");
  run_switch_a: assert property (
    !o_power_down |-> o_ref_series_closed == 2'b11 && !o_ref_shunt_switch)
    else $error("reference switches wrong while running");
  ce_low_a: assert property (
    !i_chip_enable [*6] |-> o_power_down)
    else $error("chip enable low without power-down");
endmodule

bind sdsc_top sdsc_checker u_checker (
  .i_clock            (i_clock),
  .i_rst              (i_rst),
  .i_chip_enable      (i_chip_enable),
  .i_avs_read         (i_avs_read),
  .i_avs_write        (i_avs_write),
  .o_avs_readdata     (o_avs_readdata),
  .o_avs_waitrequest  (o_avs_waitrequest),
  .o_charge_pump_up   (o_charge_pump_up),
  .o_charge_pump_down (o_charge_pump_down),
  .o_charge_pump_oe_n (o_charge_pump_oe_n),
  .o_ref_series_closed(o_ref_series_closed),
  .o_ref_shunt_switch (o_ref_shunt_switch),
  .o_power_down       (o_power_down)
);

// *** sim/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  logic        i_clock, i_rst, ce, tx, rd, wr, sclk, sdata, le;
  logic        wreq, cpu, cpd, oe_n, shunt, mux, pd, refp;
  logic [1:0]  ser;
  logic [5:0]  addr;
  logic [31:0] wdata, rdat, q;
  int          n_mismatch, compares;
  // rows: latch byte offset beside the serial word it must hold
  logic [37:0] rows [8] = '{
    {6'h20, 32'h0091D5E0}, {6'h24, 32'h0AAA8001},
    {6'h28, 32'h003F8002}, {6'h2C, 32'h5A5A0003},
    {6'h30, 32'hC0DE0004}, {6'h34, 32'h12345605},
    {6'h38, 32'hFEDCBA06}, {6'h3C, 32'h87654307}};

  sdsc_top u_dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_serial_clock(sclk),
    .i_serial_data(sdata), .i_load_strobe(le), .i_chip_enable(ce),
    .i_tx_data(tx), .i_ref_in(refp), .i_rf_feedback(1'b0),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .o_charge_pump_up(cpu), .o_charge_pump_down(cpd),
    .o_charge_pump_oe_n(oe_n), .o_ref_series_closed(ser),
    .o_ref_shunt_switch(shunt), .o_internal_signal_output(mux),
    .o_power_down(pd));
  sdsc_host_model u_host (
    .i_clock(i_clock), .o_serial_clock(sclk), .o_serial_data(sdata),
    .o_load_strobe(le));

  // comparison and closing report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // one bus transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge i_clock);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge i_clock);
      if (wreq === 1'b0) break;
    end
    if (k == 20) begin
      n_mismatch++;
      final_report();
    end
    // the accepting edge: take the data and release at once
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic ld(input logic [31:0] w);
    u_host.send(w, 32);
    repeat (8) @(posedge i_clock);
  endtask
  // cycles from one internal output pulse to the next
  task automatic gap(input int exp);
    int n;
    for (n = 0; n < 1000 && mux !== 1'b1; n++) @(posedge i_clock);
    @(posedge i_clock);
    for (n = 1; n < 1000 && mux !== 1'b1; n++) @(posedge i_clock);
    if (n == 1000) begin
      n_mismatch++;
      final_report();
    end
    chk(32'(n), 32'(exp));
  endtask
  task automatic wait_pd(input logic v);
    int k;
    for (k = 0; k < 40 && pd !== v; k++) @(posedge i_clock);
    if (pd !== v) begin
      n_mismatch++;
      final_report();
    end
  endtask

  // system clock
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  // reference input, eight system clocks per period
  initial begin
    refp = 1'b0;
    forever begin
      repeat (4) @(posedge i_clock);
      refp <= ~refp;
    end
  end

  // main sequence
  initial begin
    i_rst = 1'b1;
    ce = 1'b1;
    tx = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 6'h00;
    wdata = 32'h0;
    n_mismatch = 0;
    compares = 0;
    repeat (20) @(posedge i_clock);
    chk(32'({oe_n, shunt, ser, pd}), 32'h19);
    i_rst <= 1'b0;
    wait_pd(1'b0);
    chk(32'({oe_n, shunt, ser, pd}), 32'h06);
    rdchk(sdsc_pkg::ADDR_ACTIVE_INT, 32'(sdsc_pkg::RST_INT));
    rdchk(sdsc_pkg::ADDR_ACTIVE_FRACTIONAL_NUMERATOR, 32'h0);
    rdchk(sdsc_pkg::ADDR_ACTIVE_REF, 32'h01);
    foreach (rows[i]) begin
      ld(rows[i][31:0]);
      rdchk(rows[i][37:32], rows[i][31:0]);
      bus(1'b0, sdsc_pkg::ADDR_STATUS, 32'h0, q);
      chk(32'(q[6:4]), 32'(i));
    end
    // latch 1 and 2 wait for the next latch 0 load
    rdchk(sdsc_pkg::ADDR_ACTIVE_INT, 32'h123);
    rdchk(sdsc_pkg::ADDR_ACTIVE_FRACTIONAL_NUMERATOR, {7'h0, 12'hABC, 13'h0});
    rdchk(sdsc_pkg::ADDR_ACTIVE_REF, 32'h00);
    ld(32'h000B55E0);
    rdchk(sdsc_pkg::ADDR_ACTIVE_INT, 32'h016);
    rdchk(sdsc_pkg::ADDR_ACTIVE_FRACTIONAL_NUMERATOR, {7'h0, 12'hABC, 13'h1555});
    rdchk(sdsc_pkg::ADDR_ACTIVE_REF, 32'h7F);
    ld(32'h07FF8000);
    rdchk(sdsc_pkg::ADDR_ACTIVE_INT, 32'hFFF);
    // short word is refused
    u_host.send(32'h00000004, 31);
    repeat (8) @(posedge i_clock);
    rdchk(6'h30, 32'hC0DE0004);
    bus(1'b0, sdsc_pkg::ADDR_STATUS, 32'h0, q);
    chk(32'(q[1]), 32'h1);
    // chip enable and register power-down
    ce <= 1'b0;
    wait_pd(1'b1);
    chk(32'({oe_n, shunt, ser, pd}), 32'h19);
    ce <= 1'b1;
    wait_pd(1'b0);
    ld(32'h00000023);
    wait_pd(1'b1);
    chk(32'({oe_n, shunt, ser}), 32'hC);
    ld(32'h00000013);
    wait_pd(1'b0);
    chk(32'({oe_n, shunt, ser, pd}), 32'h16);
    ld(32'h00000003);
    // symbol pin and register access kinds
    tx <= 1'b1;
    repeat (6) @(posedge i_clock);
    bus(1'b0, sdsc_pkg::ADDR_STATUS, 32'h0, q);
    chk(32'(q[8]), 32'h1);
    bus(1'b1, sdsc_pkg::ADDR_CONTROL, 32'h7, q);
    rdchk(sdsc_pkg::ADDR_CONTROL, 32'h7);
    bus(1'b1, 6'h20, 32'hFFFFFFFF, q);
    rdchk(6'h20, 32'h07FF8000);
    bus(1'b1, 6'h1C, 32'hFFFFFFFF, q);
    rdchk(6'h1C, 32'h0);
    // reference divider pulse on the internal output: r 31, both options
    ld(32'h17FF8000);
    gap(248);
    chk(32'({cpu, cpd}), 32'h2);
    // mid-run reset returns every setting to its reset value
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    chk(32'({oe_n, shunt, ser, pd}), 32'h19);
    i_rst <= 1'b0;
    wait_pd(1'b0);
    rdchk(sdsc_pkg::ADDR_ACTIVE_INT, 32'(sdsc_pkg::RST_INT));
    rdchk(6'h20, 32'h0);
    final_report();
  end
endmodule

// *** src/sdsc_pkg.sv ***
package sdsc_pkg;

  // serial word and latch geometry
  localparam int WORD_BITS     = 32;
  localparam int SEL_BITS      = 3;
  localparam int NUM_LATCHES   = 8;
  localparam int INT_BITS      = 12;
  localparam int FRACTIONAL_NUMERATOR_BITS     = 25;
  localparam int FRACTIONAL_NUMERATOR_MSB_BITS = 12;
  localparam int FRACTIONAL_NUMERATOR_LSB_BITS = 13;
  localparam int RDIV_BITS     = 5;
  localparam int MUX_BITS      = 4;
  localparam int PIN_COUNT     = 7;
  localparam logic [5:0] WORD_COUNT = 6'h20;

  // latch indices
  localparam logic [2:0] LATCH_FRACTIONAL_NUMERATOR_INT = 3'h0;
  localparam logic [2:0] LATCH_FRACTIONAL_NUMERATOR_LSB = 3'h1;
  localparam logic [2:0] LATCH_REF_DIV  = 3'h2;
  localparam logic [2:0] LATCH_FUNCTION = 3'h3;

  // field positions inside the latched words
  localparam int R0_FRACTIONAL_NUMERATOR_MSB_LSB  = 3;
  localparam int R0_INT_LSB       = 15;
  localparam int R0_MUX_LSB       = 27;
  localparam int R1_FRACTIONAL_NUMERATOR_LSB_LSB  = 15;
  localparam int R2_RDIV_LSB      = 15;
  localparam int R2_DOUBLER_BIT   = 20;
  localparam int R2_HALVER_BIT    = 21;
  localparam int R3_CNT_RESET_BIT = 3;
  localparam int R3_CP_TRI_BIT    = 4;
  localparam int R3_PWR_DOWN_BIT  = 5;

  // divider limits and reset values
  localparam logic [11:0] INT_MIN      = 12'h017;
  localparam logic [11:0] RST_INT      = 12'h017;
  localparam logic [4:0]  RST_RDIV     = 5'h01;
  localparam logic [5:0]  RDIV_FULL    = 6'h20;
  localparam logic [24:0] RST_FRACTIONAL_NUMERATOR     = 25'h0000000;
  localparam logic [2:0]  RST_CONTROL  = 3'h0;

  // internal signal output select codes
  localparam logic [3:0] MUX_LOW      = 4'h0;
  localparam logic [3:0] MUX_HIGH     = 4'h1;
  localparam logic [3:0] MUX_REF_DIV  = 4'h2;
  localparam logic [3:0] MUX_FB_DIV   = 4'h3;
  localparam logic [3:0] MUX_CP_UP    = 4'h4;
  localparam logic [3:0] MUX_CP_DOWN  = 4'h5;
  localparam logic [3:0] MUX_SYMBOL   = 4'h6;

  // bus register byte offsets
  localparam logic [5:0] ADDR_CONTROL     = 6'h00;
  localparam logic [5:0] ADDR_FSK_DEV     = 6'h04;
  localparam logic [5:0] ADDR_PSK_PHASE   = 6'h08;
  localparam logic [5:0] ADDR_STATUS      = 6'h0C;
  localparam logic [5:0] ADDR_ACTIVE_INT  = 6'h10;
  localparam logic [5:0] ADDR_ACTIVE_FRACTIONAL_NUMERATOR = 6'h14;
  localparam logic [5:0] ADDR_ACTIVE_REF  = 6'h18;
  localparam int         ADDR_LATCH_BIT   = 5;

  // control register bits
  localparam int CTRL_FSK_BIT    = 0;
  localparam int CTRL_PSK_BIT    = 1;
  localparam int CTRL_TX_INV_BIT = 2;

endpackage

// *** src/sdsc_sync.sv ***
`timescale 1ns/1ns
module sdsc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage_one;

  // two flops, the first read only by the second
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      stage_one <= '0;
      o_sync    <= '0;
    end else begin
      stage_one <= i_async;
      o_sync    <= stage_one;
    end
  end

endmodule

// *** src/sdsc_top.sv ***
`timescale 1ns/1ns
module sdsc_top (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_serial_clock,
  input  wire logic        i_serial_data,
  input  wire logic        i_load_strobe,
  input  wire logic        i_chip_enable,
  input  wire logic        i_tx_data,
  input  wire logic        i_ref_in,
  input  wire logic        i_rf_feedback,
  input  wire logic [5:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic             o_charge_pump_up,
  output logic             o_charge_pump_down,
  output logic             o_charge_pump_oe_n,
  output logic      [1:0]  o_ref_series_closed,
  output logic             o_ref_shunt_switch,
  output logic             o_internal_signal_output,
  output logic             o_power_down
);

  localparam int WB = sdsc_pkg::WORD_BITS;
  localparam int FB = sdsc_pkg::FRACTIONAL_NUMERATOR_BITS;
  localparam int IB = sdsc_pkg::INT_BITS;

  logic [sdsc_pkg::PIN_COUNT-1:0] pins_s;
  logic [sdsc_pkg::PIN_COUNT-1:0] pins_d;
  logic [WB-1:0]                  shift_reg;
  logic [5:0]                     bit_count;
  logic                           short_word;
  logic [2:0]                     last_sel;
  logic [WB-1:0]                  latch_mem [0:sdsc_pkg::NUM_LATCHES-1];
  logic [IB-1:0]                  active_int;
  logic [FB-1:0]                  active_fractional_numerator;
  logic [4:0]                     active_rdiv;
  logic                           active_doubler;
  logic                           active_halver;
  logic [6:0]                     ref_cnt;
  logic                           ref_pulse;
  logic [12:0]                    fb_cnt;
  logic [12:0]                    n_cur;
  logic [FB:0]                    acc;
  logic                           fb_pulse;
  logic                           sym_d;
  logic                           psk_pending;
  logic                           pc_up;
  logic                           pc_down;
  logic [2:0]                     control;
  logic [FB-1:0]                  fsk_dev;
  logic [FB-1:0]                  psk_phase;
  logic                           bus_ack;
  logic [31:0]                    next_readdata;
  integer                         li;

  // pin synchronisers
  sdsc_sync #(
    .WIDTH (sdsc_pkg::PIN_COUNT)
  ) u_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async ({i_rf_feedback, i_ref_in, i_tx_data, i_chip_enable,
               i_load_strobe, i_serial_data, i_serial_clock}),
    .o_sync  (pins_s)
  );

  // synchronised pins and edge detection
  wire pin_sclk   = pins_s[0];
  wire pin_sdata  = pins_s[1];
  wire pin_le     = pins_s[2];
  wire pin_ce     = pins_s[3];
  wire pin_tx     = pins_s[4];
  wire pin_ref    = pins_s[5];
  wire pin_rf     = pins_s[6];
  wire sclk_rise  = pin_sclk & ~pins_d[0];
  wire le_rise    = pin_le & ~pins_d[2];
  wire ref_rise   = pin_ref & ~pins_d[5];
  wire ref_fall   = ~pin_ref & pins_d[5];
  wire rf_rise    = pin_rf & ~pins_d[6];

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pins_d <= '0;
    end else begin
      pins_d <= pins_s;
    end
  end

  // word framing and latch select
  wire       word_ok   = (bit_count == sdsc_pkg::WORD_COUNT);
  wire       load_fire = le_rise & word_ok;
  wire [2:0] sel       = shift_reg[sdsc_pkg::SEL_BITS-1:0];
  wire       r0_load   = load_fire & (sel == sdsc_pkg::LATCH_FRACTIONAL_NUMERATOR_INT);

  // serial shift register, newest bit enters at the bottom
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      shift_reg <= '0;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[WB-2:0], pin_sdata};
    end
  end

  // bit counter saturates at a full word, cleared by the strobe
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      bit_count <= 6'h00;
    end else if (le_rise) begin
      bit_count <= 6'h00;
    end else if (sclk_rise && !word_ok) begin
      bit_count <= bit_count + 6'h01;
    end
  end

  // framing status of the last strobe
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      short_word <= 1'b0;
      last_sel   <= 3'h0;
    end else if (le_rise) begin
      short_word <= ~word_ok;
      if (word_ok) begin
        last_sel <= sel;
      end
    end
  end

  // eight latches, a short word is refused
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      for (li = 0; li < sdsc_pkg::NUM_LATCHES; li = li + 1) begin
        latch_mem[li] <= '0;
      end
    end else if (load_fire) begin
      latch_mem[sel] <= shift_reg;
    end
  end

  // fields of the stored latches
  wire [WB-1:0] r1_word  = latch_mem[sdsc_pkg::LATCH_FRACTIONAL_NUMERATOR_LSB];
  wire [WB-1:0] r2_word  = latch_mem[sdsc_pkg::LATCH_REF_DIV];
  wire [WB-1:0] r3_word  = latch_mem[sdsc_pkg::LATCH_FUNCTION];
  wire [3:0]    mux_sel  =
    latch_mem[sdsc_pkg::LATCH_FRACTIONAL_NUMERATOR_INT][sdsc_pkg::R0_MUX_LSB +: 4];
  wire          cnt_rst  = r3_word[sdsc_pkg::R3_CNT_RESET_BIT];
  wire          cp_tri   = r3_word[sdsc_pkg::R3_CP_TRI_BIT];
  wire          power_down = ~pin_ce | r3_word[sdsc_pkg::R3_PWR_DOWN_BIT];
  wire          hold     = power_down | cnt_rst;

  // buffered settings move in only with a latch zero write
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      active_int     <= sdsc_pkg::RST_INT;
      active_fractional_numerator    <= sdsc_pkg::RST_FRACTIONAL_NUMERATOR;
      active_rdiv    <= sdsc_pkg::RST_RDIV;
      active_doubler <= 1'b0;
      active_halver  <= 1'b0;
    end else if (r0_load) begin
      active_int     <= shift_reg[sdsc_pkg::R0_INT_LSB +: IB];
      active_fractional_numerator    <= {shift_reg[sdsc_pkg::R0_FRACTIONAL_NUMERATOR_MSB_LSB +:
                                   sdsc_pkg::FRACTIONAL_NUMERATOR_MSB_BITS],
                         r1_word[sdsc_pkg::R1_FRACTIONAL_NUMERATOR_LSB_LSB +:
                                 sdsc_pkg::FRACTIONAL_NUMERATOR_LSB_BITS]};
      active_rdiv    <= r2_word[sdsc_pkg::R2_RDIV_LSB +:
                                sdsc_pkg::RDIV_BITS];
      active_doubler <= r2_word[sdsc_pkg::R2_DOUBLER_BIT];
      active_halver  <= r2_word[sdsc_pkg::R2_HALVER_BIT];
    end
  end

  // reference path: doubler counts both edges, halver doubles the count
  wire [5:0] rdiv_val  = (active_rdiv == 5'h00) ? sdsc_pkg::RDIV_FULL
                                                : {1'b0, active_rdiv};
  wire [6:0] ref_term  = active_halver ? {rdiv_val, 1'b0}
                                       : {1'b0, rdiv_val};
  wire [6:0] ref_last  = ref_term - 7'h01;
  wire       ref_event = ref_rise | (active_doubler & ref_fall);

  // reference divider feeding the phase comparator
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ref_cnt   <= 7'h00;
      ref_pulse <= 1'b0;
    end else if (hold) begin
      ref_cnt   <= 7'h00;
      ref_pulse <= 1'b0;
    end else begin
      ref_pulse <= ref_event && (ref_cnt == ref_last);
      if (ref_event) begin
        ref_cnt <= (ref_cnt == ref_last) ? 7'h00 : ref_cnt + 7'h01;
      end
    end
  end

  // modulation symbol and keyed fractional value
  wire          symbol   = pin_tx ^ control[sdsc_pkg::CTRL_TX_INV_BIT];
  wire [FB-1:0] fractional_numerator_fsk = active_fractional_numerator + fsk_dev;
  wire [FB-1:0] fractional_numerator_mod = (control[sdsc_pkg::CTRL_FSK_BIT] & symbol)
                           ? fractional_numerator_fsk : active_fractional_numerator;
  wire          psk_kick = control[sdsc_pkg::CTRL_PSK_BIT] &
                           (symbol != sym_d);

  // first order interpolator, the extra lsb is the half-step offset
  wire [FB:0]   psk_add  = psk_pending ? {psk_phase, 1'b0} : '0;
  wire [FB+1:0] acc_sum  = {1'b0, acc} + {1'b0, fractional_numerator_mod, 1'b1}
                           + {1'b0, psk_add};
  wire          carry    = acc_sum[FB+1];
  wire [IB-1:0] int_eff  = (active_int < sdsc_pkg::INT_MIN)
                           ? sdsc_pkg::INT_MIN : active_int;
  wire [12:0]   n_next   = {1'b0, int_eff} + {12'h000, carry};
  wire [12:0]   fb_last  = n_cur - 13'h0001;
  wire          fb_wrap  = rf_rise && (fb_cnt == fb_last);

  // feedback divider reloads integer plus carry each cycle
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      fb_cnt   <= 13'h0000;
      n_cur    <= {1'b0, sdsc_pkg::RST_INT};
      acc      <= '0;
      fb_pulse <= 1'b0;
    end else if (hold) begin
      fb_cnt   <= 13'h0000;
      n_cur    <= {1'b0, int_eff};
      acc      <= '0;
      fb_pulse <= 1'b0;
    end else begin
      fb_pulse <= fb_wrap;
      if (fb_wrap) begin
        fb_cnt <= 13'h0000;
        n_cur  <= n_next;
        acc    <= acc_sum[FB:0];
      end else if (rf_rise) begin
        fb_cnt <= fb_cnt + 13'h0001;
      end
    end
  end

  // one phase shift per symbol change, a new change wins over the clear
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sym_d       <= 1'b0;
      psk_pending <= 1'b0;
    end else begin
      sym_d <= symbol;
      if (psk_kick) begin
        psk_pending <= 1'b1;
      end else if (fb_wrap) begin
        psk_pending <= 1'b0;
      end
    end
  end

  // phase comparator: up on reference, down on feedback, both reset
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pc_up   <= 1'b0;
      pc_down <= 1'b0;
    end else if (hold || (pc_up && pc_down)) begin
      pc_up   <= 1'b0;
      pc_down <= 1'b0;
    end else begin
      pc_up   <= pc_up | ref_pulse;
      pc_down <= pc_down | fb_pulse;
    end
  end

  // internal signal selection
  wire mux_bit = (mux_sel == sdsc_pkg::MUX_HIGH)    ? 1'b1 :
                 (mux_sel == sdsc_pkg::MUX_REF_DIV) ? ref_pulse :
                 (mux_sel == sdsc_pkg::MUX_FB_DIV)  ? fb_pulse :
                 (mux_sel == sdsc_pkg::MUX_CP_UP)   ? pc_up :
                 (mux_sel == sdsc_pkg::MUX_CP_DOWN) ? pc_down :
                 (mux_sel == sdsc_pkg::MUX_SYMBOL)  ? symbol : 1'b0;

  // pin outputs; pump floats and reference is unloaded in power-down
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_charge_pump_up         <= 1'b0;
      o_charge_pump_down       <= 1'b0;
      o_charge_pump_oe_n       <= 1'b1;
      o_ref_series_closed      <= 2'h0;
      o_ref_shunt_switch       <= 1'b1;
      o_internal_signal_output <= 1'b0;
      o_power_down             <= 1'b1;
    end else begin
      o_charge_pump_up         <= pc_up & ~power_down;
      o_charge_pump_down       <= pc_down & ~power_down;
      o_charge_pump_oe_n       <= power_down | cp_tri;
      o_ref_series_closed      <= {2{~power_down}};
      o_ref_shunt_switch       <= power_down;
      o_internal_signal_output <= mux_bit;
      o_power_down             <= power_down;
    end
  end

  // bus decode: one wait cycle, then the access completes
  wire        bus_access = i_avs_read | i_avs_write;
  wire        wr_fire    = i_avs_write & bus_ack;
  wire        in_latch   = i_avs_address[sdsc_pkg::ADDR_LATCH_BIT];
  wire        hit_ctrl   = ~in_latch &
                           (i_avs_address == sdsc_pkg::ADDR_CONTROL);
  wire        hit_fsk    = ~in_latch &
                           (i_avs_address == sdsc_pkg::ADDR_FSK_DEV);
  wire        hit_psk    = ~in_latch &
                           (i_avs_address == sdsc_pkg::ADDR_PSK_PHASE);
  wire [31:0] be_mask    = {{8{i_avs_byteenable[3]}},
                            {8{i_avs_byteenable[2]}},
                            {8{i_avs_byteenable[1]}},
                            {8{i_avs_byteenable[0]}}};
  wire [31:0] ctrl_word  = {29'h0, control};
  wire [31:0] fsk_word   = {7'h00, fsk_dev};
  wire [31:0] psk_word   = {7'h00, psk_phase};
  wire [31:0] ctrl_new   = (ctrl_word & ~be_mask) | (i_avs_writedata & be_mask);
  wire [31:0] fsk_new    = (fsk_word & ~be_mask) | (i_avs_writedata & be_mask);
  wire [31:0] psk_new    = (psk_word & ~be_mask) | (i_avs_writedata & be_mask);
  wire [31:0] status_word = {23'h0, symbol, 1'b0, last_sel, 2'h0,
                             short_word, power_down};

  assign o_avs_waitrequest = bus_access & ~bus_ack;

  // read data selection, unmapped offsets read zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (in_latch) begin
      next_readdata = latch_mem[i_avs_address[4:2]];
    end else begin
      case (i_avs_address)
        sdsc_pkg::ADDR_CONTROL:     next_readdata = ctrl_word;
        sdsc_pkg::ADDR_FSK_DEV:     next_readdata = fsk_word;
        sdsc_pkg::ADDR_PSK_PHASE:   next_readdata = psk_word;
        sdsc_pkg::ADDR_STATUS:      next_readdata = status_word;
        sdsc_pkg::ADDR_ACTIVE_INT:  next_readdata = {20'h0, active_int};
        sdsc_pkg::ADDR_ACTIVE_FRACTIONAL_NUMERATOR: next_readdata = {7'h00, active_fractional_numerator};
        sdsc_pkg::ADDR_ACTIVE_REF:  next_readdata = {25'h0, active_halver,
                                                     active_doubler,
                                                     active_rdiv};
        default:                    next_readdata = 32'h0000_0000;
      endcase
    end
  end

  // bus handshake and read data register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      bus_ack        <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      bus_ack <= bus_access & ~bus_ack;
      if (i_avs_read && !bus_ack) begin
        o_avs_readdata <= next_readdata;
      end
    end
  end

  // software keying registers
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      control   <= sdsc_pkg::RST_CONTROL;
      fsk_dev   <= '0;
      psk_phase <= '0;
    end else if (wr_fire) begin
      if (hit_ctrl) begin
        control <= ctrl_new[2:0];
      end
      if (hit_fsk) begin
        fsk_dev <= fsk_new[FB-1:0];
      end
      if (hit_psk) begin
        psk_phase <= psk_new[FB-1:0];
      end
    end
  end

endmodule
